// [gdl_pkg.sv]
// register map, reset values and field decodes for the gate-drive loop configuration bank
package gdl_pkg;
   localparam int         GDL_AW          = 8;
   localparam int         GDL_DW          = 8;
   localparam logic [7:0] GDL_OFS_SLEW78  = 8'h38;
   localparam logic [7:0] GDL_OFS_COMP    = 8'h39;
   localparam logic [7:0] GDL_OFS_FWPD    = 8'h3a;
   localparam logic [7:0] GDL_OFS_PCGAIN  = 8'h3b;
   localparam logic [7:0] GDL_RST_SLEW78  = 8'h23;
   localparam logic [7:0] GDL_RST_COMP    = 8'h00;
   localparam logic [7:0] GDL_RST_FWPD    = 8'h0f;
   localparam logic [7:0] GDL_RST_PCGAIN  = 8'h55;
   // pair-7/8 slew register field positions
   localparam int         GDL_SLEW_TGT_LSB = 4;
   localparam int         GDL_SLEW_EN_BIT  = 3;
   localparam int         GDL_SLEW_ERR_BIT = 2;
   localparam int         GDL_SLEW_KP_LSB  = 0;
   // compensation / freewheel register halves
   localparam int         GDL_HI_NIB_LSB   = 4;
   localparam int         GDL_LO_NIB_LSB   = 0;
   // slew target table in nanoseconds, code 0 to 15
   localparam logic [13:0] GDL_SLEW_NS [16] = '{
      14'd350,  14'd560,  14'd770,  14'd980,  14'd1330, 14'd1680, 14'd2030, 14'd2450,
      14'd2940, 14'd3990, 14'd4970, 14'd5950, 14'd7980, 14'd9940, 14'd11970, 14'd15960};
   // freewheel gate current in mA while a pair's select bit is set
   localparam logic [6:0] GDL_FW_FIXED_MA = 7'd64;
endpackage : gdl_pkg

// [gdl_reg8.sv]
// one 8-bit read/write configuration register with write strobe
`timescale 1ns/1ps
module gdl_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST_N,
   input  wire logic       WR_EN,
   input  wire logic [7:0] WR_DATA,
   output logic      [7:0] Q
);
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         Q <= RESET_VAL;
      end else if (WR_EN) begin
         Q <= WR_DATA;
      end
   end
endmodule : gdl_reg8

// [gdl_regs.sv]
// gate-drive loop configuration register bank with decoded field outputs
`timescale 1ns/1ps
module gdl_regs
   import gdl_pkg::*;
(
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   // register access port
   input  wire logic [GDL_AW-1:0] REG_ADDR,
   input  wire logic              REG_WR,
   input  wire logic [GDL_DW-1:0] REG_WDATA,
   output logic      [GDL_DW-1:0] REG_RDATA,
   output logic                   REG_HIT,
   // pair-7/8 slew loop
   output logic      [3:0]        SLEW_TARGET_CODE_PAIR4,
   output logic      [13:0]       SLEW_TARGET_NS_PAIR4,
   output logic                   SLEW_LOOP_ENABLE_PAIR4,
   output logic                   SLEW_ERROR_LIMIT_PAIR4,
   output logic      [2:0]        SLEW_GAIN_PAIR4,
   // per pair, index 3 is pair 1/2, index 0 is pair 7/8
   output logic      [3:0]        DUTY_COMP_ENABLE,
   output logic      [3:0]        POLARITY_MANUAL,
   output logic      [3:0]        FREEWHEEL_CURRENT_SELECT,
   output logic      [3:0]        POSTCHARGE_DELAY_ENABLE,
   output logic      [15:0]       POSTCHARGE_GAIN,
   output logic      [3:0]        POSTCHARGE_ENABLE
);
   logic [7:0]  slew_r, comp_r, fwpd_r, pcg_r;
   logic        wr_slew, wr_comp, wr_fwpd, wr_pcg;
   // register values as they will stand after this edge
   logic [7:0]  slew_nxt, pcg_nxt;
   logic [13:0] slew_ns_r;
   logic [2:0]  slew_gain_r;
   logic [15:0] pcg_gain_r, pcg_gain_nxt;
   logic [3:0]  pcg_en_r, pcg_en_nxt;

   // post-charge gain code to gain value; zero means the loop is off
   function automatic logic [3:0] pcg_decode(input logic [1:0] code);
      case (code)
         2'b00:   pcg_decode = 4'h0;
         2'b01:   pcg_decode = 4'h2;
         2'b10:   pcg_decode = 4'h4;
         default: pcg_decode = 4'hf;
      endcase
   endfunction : pcg_decode

   // decoded outputs start from the decode of the register reset values
   localparam logic [13:0] SLEW_NS_RST   = GDL_SLEW_NS[GDL_RST_SLEW78[GDL_SLEW_TGT_LSB +: 4]];
   localparam logic [2:0]  SLEW_GAIN_RST = {1'b0, GDL_RST_SLEW78[GDL_SLEW_KP_LSB +: 2]} + 3'd1;
   localparam logic [15:0] PCG_GAIN_RST  = {pcg_decode(GDL_RST_PCGAIN[7:6]), pcg_decode(GDL_RST_PCGAIN[5:4]),
                                            pcg_decode(GDL_RST_PCGAIN[3:2]), pcg_decode(GDL_RST_PCGAIN[1:0])};
   localparam logic [3:0]  PCG_EN_RST    = {|GDL_RST_PCGAIN[7:6], |GDL_RST_PCGAIN[5:4],
                                            |GDL_RST_PCGAIN[3:2], |GDL_RST_PCGAIN[1:0]};

   // field map and offsets assume 8-bit data and 8-bit offsets
   if (GDL_DW != 8 || GDL_AW != 8) begin : g_bad_size
      $error("register bank needs 8-bit data and 8-bit offsets");
   end

   assign wr_slew = REG_WR && (REG_ADDR == GDL_OFS_SLEW78);
   assign wr_comp = REG_WR && (REG_ADDR == GDL_OFS_COMP);
   assign wr_fwpd = REG_WR && (REG_ADDR == GDL_OFS_FWPD);
   assign wr_pcg  = REG_WR && (REG_ADDR == GDL_OFS_PCGAIN);

   gdl_reg8 #(.RESET_VAL(GDL_RST_SLEW78)) u_slew (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR_EN(wr_slew), .WR_DATA(REG_WDATA), .Q(slew_r));
   gdl_reg8 #(.RESET_VAL(GDL_RST_COMP)) u_comp (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR_EN(wr_comp), .WR_DATA(REG_WDATA), .Q(comp_r));
   gdl_reg8 #(.RESET_VAL(GDL_RST_FWPD)) u_fwpd (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR_EN(wr_fwpd), .WR_DATA(REG_WDATA), .Q(fwpd_r));
   gdl_reg8 #(.RESET_VAL(GDL_RST_PCGAIN)) u_pcg (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR_EN(wr_pcg), .WR_DATA(REG_WDATA), .Q(pcg_r));

   // read mux; unmapped offsets read zero
   always_comb begin
      REG_HIT = 1'b1;
      case (REG_ADDR)
         GDL_OFS_SLEW78: REG_RDATA = slew_r;
         GDL_OFS_COMP:   REG_RDATA = comp_r;
         GDL_OFS_FWPD:   REG_RDATA = fwpd_r;
         GDL_OFS_PCGAIN: REG_RDATA = pcg_r;
         default: begin
            REG_RDATA = 8'h00;
            REG_HIT   = 1'b0;
         end
      endcase
   end

   assign SLEW_TARGET_CODE_PAIR4 = slew_r[GDL_SLEW_TGT_LSB +: 4];
   assign SLEW_TARGET_NS_PAIR4   = slew_ns_r;
   assign SLEW_LOOP_ENABLE_PAIR4 = slew_r[GDL_SLEW_EN_BIT];
   assign SLEW_ERROR_LIMIT_PAIR4 = slew_r[GDL_SLEW_ERR_BIT];
   assign SLEW_GAIN_PAIR4        = slew_gain_r;
   assign DUTY_COMP_ENABLE         = comp_r[GDL_HI_NIB_LSB +: 4];
   assign POLARITY_MANUAL          = comp_r[GDL_LO_NIB_LSB +: 4];
   assign FREEWHEEL_CURRENT_SELECT = fwpd_r[GDL_HI_NIB_LSB +: 4];
   assign POSTCHARGE_DELAY_ENABLE  = fwpd_r[GDL_LO_NIB_LSB +: 4];

   // decodes sit in flops loaded from the value the register takes at the same
   // edge, so they move together with the register and never glitch downstream
   assign slew_nxt = wr_slew ? REG_WDATA : slew_r;
   assign pcg_nxt  = wr_pcg ? REG_WDATA : pcg_r;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         slew_ns_r   <= SLEW_NS_RST;
         slew_gain_r <= SLEW_GAIN_RST;
      end else begin
         slew_ns_r   <= GDL_SLEW_NS[slew_nxt[GDL_SLEW_TGT_LSB +: 4]];
         // gain is code plus one
         slew_gain_r <= {1'b0, slew_nxt[GDL_SLEW_KP_LSB +: 2]} + 3'd1;
      end
   end

   // post-charge gain decode, 4 bits per pair, pair 1/2 in the top nibble
   for (genvar i = 0; i < 4; i++) begin : g_pcg
      assign pcg_gain_nxt[4*i +: 4] = pcg_decode(pcg_nxt[2*i +: 2]);
      assign pcg_en_nxt[i]          = |pcg_nxt[2*i +: 2];
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pcg_gain_r <= PCG_GAIN_RST;
         pcg_en_r   <= PCG_EN_RST;
      end else begin
         pcg_gain_r <= pcg_gain_nxt;
         pcg_en_r   <= pcg_en_nxt;
      end
   end

   assign POSTCHARGE_GAIN   = pcg_gain_r;
   assign POSTCHARGE_ENABLE = pcg_en_r;

   // checks
   property p_slew_readback;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_slew |=> (REG_ADDR != GDL_OFS_SLEW78) || REG_WR || (REG_RDATA == $past(REG_WDATA));
   endproperty
   a_slew_readback: assert property (p_slew_readback) else $error("slew readback wrong");
   property p_slew_table;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (SLEW_TARGET_CODE_PAIR4 == 4'hf) |-> (SLEW_TARGET_NS_PAIR4 == 14'd15960);
   endproperty
   a_slew_table: assert property (p_slew_table) else $error("slew table top wrong");
   property p_en;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_slew |=> SLEW_LOOP_ENABLE_PAIR4 == $past(REG_WDATA[3]);
   endproperty
   a_en: assert property (p_en) else $error("slew enable not updated");
   property p_err;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_slew |=> SLEW_ERROR_LIMIT_PAIR4 == $past(REG_WDATA[2]);
   endproperty
   a_err: assert property (p_err) else $error("error limit not updated");
   property p_gain;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_slew |=> SLEW_GAIN_PAIR4 == {1'b0, $past(REG_WDATA[1:0])} + 3'd1;
   endproperty
   a_gain: assert property (p_gain) else $error("slew gain wrong");
   property p_comp;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_comp |=> {DUTY_COMP_ENABLE, POLARITY_MANUAL} == $past(REG_WDATA);
   endproperty
   a_comp: assert property (p_comp) else $error("compensation fields wrong");
   property p_comp_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !wr_comp |=> $stable(POLARITY_MANUAL);
   endproperty
   a_comp_hold: assert property (p_comp_hold) else $error("polarity mode changed unwritten");
   property p_fw;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_fwpd |=> {FREEWHEEL_CURRENT_SELECT, POSTCHARGE_DELAY_ENABLE} == $past(REG_WDATA);
   endproperty
   a_fw: assert property (p_fw) else $error("freewheel fields wrong");
   property p_fw_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !wr_fwpd |=> $stable(POSTCHARGE_DELAY_ENABLE);
   endproperty
   a_fw_hold: assert property (p_fw_hold) else $error("post delay changed unwritten");
   property p_pcg;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (pcg_r[7:6] == 2'b11) |-> (POSTCHARGE_GAIN[15:12] == 4'hf) && POSTCHARGE_ENABLE[3];
   endproperty
   a_pcg: assert property (p_pcg) else $error("post gain decode wrong");
   property p_rst;
      @(posedge CORE_CLK) $rose(RST_N) |-> (fwpd_r == 8'h0f) && (pcg_r == 8'h55)
         && (slew_r == GDL_RST_SLEW78) && (comp_r == GDL_RST_COMP);
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   c_wr_slew: cover property (@(posedge CORE_CLK) disable iff (!RST_N) wr_slew);
   c_wr_pcg:  cover property (@(posedge CORE_CLK) disable iff (!RST_N) wr_pcg);
   c_miss:    cover property (@(posedge CORE_CLK) disable iff (!RST_N) REG_WR && !REG_HIT);
   c_b2b:     cover property (@(posedge CORE_CLK) disable iff (!RST_N) wr_comp ##1 wr_fwpd);
   // a refused write must leave every register alone
   property p_miss_write;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REG_WR && !REG_HIT) |=> $stable(slew_r) && $stable(comp_r) && $stable(fwpd_r) && $stable(pcg_r);
   endproperty
   a_miss_write: assert property (p_miss_write) else $error("unmapped write changed a register");
   property p_miss_read;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !REG_HIT |-> (REG_RDATA == 8'h00);
   endproperty
   a_miss_read: assert property (p_miss_read) else $error("unmapped offset read nonzero");
   property p_slew_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !wr_slew |=> $stable(slew_r) && $stable(SLEW_TARGET_NS_PAIR4) && $stable(SLEW_GAIN_PAIR4);
   endproperty
   a_slew_hold: assert property (p_slew_hold) else $error("slew fields changed unwritten");
   property p_ns_track;
      @(posedge CORE_CLK) disable iff (!RST_N)
      SLEW_TARGET_NS_PAIR4 == GDL_SLEW_NS[SLEW_TARGET_CODE_PAIR4];
   endproperty
   a_ns_track: assert property (p_ns_track) else $error("slew time out of step with code");
   property p_pcg_off;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (pcg_r[1:0] == 2'b00) |-> (POSTCHARGE_GAIN[3:0] == 4'h0) && !POSTCHARGE_ENABLE[0];
   endproperty
   a_pcg_off: assert property (p_pcg_off) else $error("post gain not disabled");
endmodule : gdl_regs

// [gdl_regs_bench.sv]
// self-checking bench for the gate-drive loop configuration bank
`timescale 1ns/1ps
module gdl_regs_bench;
   import gdl_pkg::*;
   logic        CORE_CLK, RST_N, REG_WR, REG_HIT, sen, serr;
   logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
   logic [3:0]  tcode, dce, pman, fws, pde, pce;
   logic [13:0] tns;
   logic [2:0]  sgain;
   logic [15:0] pcg;
   logic [7:0]  sh [4];
   int          fails, samples_checked;
   // rows: expected hit, address, write data
   logic [16:0] rows [10] = '{{1'b1, 8'h39, 8'ha5}, {1'b1, 8'h39, 8'h5a}, {1'b1, 8'h3a, 8'hf0},
      {1'b1, 8'h3a, 8'h00}, {1'b1, 8'h3b, 8'h1b}, {1'b1, 8'h3b, 8'he4}, {1'b1, 8'h3b, 8'h00},
      {1'b0, 8'h3c, 8'hff}, {1'b0, 8'h37, 8'hff}, {1'b1, 8'h38, 8'h7e}};
   logic [13:0] ns_tab [16] = '{14'h15e, 14'h230, 14'h302, 14'h3d4, 14'h532, 14'h690, 14'h7ee, 14'h992,
      14'hb7c, 14'hf96, 14'h136a, 14'h173e, 14'h1f2c, 14'h26d4, 14'h2ec2, 14'h3e58};
   logic [3:0]  pg_tab [4] = '{4'h0, 4'h2, 4'h4, 4'hf};
   logic [2:0]  kp_tab [4] = '{3'd1, 3'd2, 3'd3, 3'd4};

   gdl_regs u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
      .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .SLEW_TARGET_CODE_PAIR4(tcode),
      .SLEW_TARGET_NS_PAIR4(tns), .SLEW_LOOP_ENABLE_PAIR4(sen), .SLEW_ERROR_LIMIT_PAIR4(serr),
      .SLEW_GAIN_PAIR4(sgain), .DUTY_COMP_ENABLE(dce), .POLARITY_MANUAL(pman),
      .FREEWHEEL_CURRENT_SELECT(fws), .POSTCHARGE_DELAY_ENABLE(pde), .POSTCHARGE_GAIN(pcg),
      .POSTCHARGE_ENABLE(pce));

   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   // drive just after an edge, hold through the next one
   task put(input logic [7:0] a, input logic [7:0] d, input logic w);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = w;
      @(posedge CORE_CLK);
      #1;
   endtask : put

   task wr(input logic [7:0] a, input logic [7:0] d);
      put(a, d, 1'b1);
      if (a inside {[8'h38:8'h3b]} && RST_N === 1'b1) sh[a[1:0]] = d;
   endtask : wr

   task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task reads();
      for (int i = 0; i < 4; i++) begin
         put(8'h38 + 8'(i), 8'h00, 1'b0);
         chk("rdata", REG_RDATA, sh[i]); // read back
      end
      chk("tcode", tcode, sh[0][7:4]); // target code
      chk("tns", tns, ns_tab[sh[0][7:4]]); // target time
      chk("slen", sen, sh[0][3]); // loop enable
      chk("serr", serr, sh[0][2]); // error limit
      chk("sgain", sgain, kp_tab[sh[0][1:0]]); // gain
      chk("dce", dce, sh[1][7:4]); // compensation enables
      chk("pman", pman, sh[1][3:0]); // polarity mode
      chk("fws", fws, sh[2][7:4]); // freewheel current
      chk("pde", pde, sh[2][3:0]); // post-charge delay
      for (int j = 0; j < 4; j++) begin
         chk("pcg", pcg[4*j+:4], pg_tab[sh[3][2*j+:2]]); // gain nibble
         chk("pce", pce[j], |sh[3][2*j+:2]); // gain enable
      end
   endtask : reads

   task complete_run();
      $display("checked %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run

   initial begin
      RST_N = 1'b0;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      fails = 0;
      samples_checked = 0;
      sh = '{8'h23, 8'h00, 8'h0f, 8'h55};
      repeat (16) @(posedge CORE_CLK);
      #1 RST_N = 1'b1;
      reads();
      for (int r = 0; r < 10; r++) begin
         wr(rows[r][15:8], rows[r][7:0]);
         put(rows[r][15:8], 8'h00, 1'b0);
         chk("hit", REG_HIT, rows[r][16]); // decode
         chk("rd", REG_RDATA, rows[r][16] ? rows[r][7:0] : 8'h00); // unmapped reads zero
         reads();
      end
      for (int c = 0; c < 16; c++) begin
         wr(8'h38, {4'(c), 4'(c)});
         reads();
      end
      // back-to-back writes with the strobe held high
      wr(8'h39, 8'h3c);
      wr(8'h3a, 8'hc3);
      wr(8'h3b, 8'h9c);
      reads();
      // mid-run reset, a write while held must be lost
      RST_N = 1'b0;
      sh = '{8'h23, 8'h00, 8'h0f, 8'h55};
      wr(8'h38, 8'hff);
      reads();
      RST_N = 1'b1;
      wr(8'h3b, 8'h00);
      reads();
      complete_run();
   end
endmodule : gdl_regs_bench
